/* File: hdl/ddr2_pin_core.sv */
// Command decode, mode registers, banks, array and data pins of the memory.
`timescale 1ns/100ps

// Summary of operation
// - Masked write bytes leave memory unchanged unless redundant read strobe is on
// - Mask sampled on both strobe edges
// - Single-lane mask pin may become read strobe
// - Bank inputs pick each command's bank
// - Bank inputs pick target mode register
// - Address gives row, or column plus precharge
// - Precharge bit ten closes one or all
// - Address carries mode register opcode
// - Read strobe edge-aligned, write strobe centred
// - Each byte lane has its own strobe
// - Mode bit ten turns complement strobes off
// - Mode bit eleven enables redundant read strobe
// - Chip select high masks all commands
module ddr2_pin_core
  import ddr2_pin_pkg::*;
#(
  parameter int LANES     = LANES_DEF,
  parameter int CAS_LAT   = CAS_LAT_DEF,
  parameter int BURST_LEN = BURST_LEN_DEF,
  parameter int ROW_BITS  = ROW_BITS_DEF,
  parameter int COL_BITS  = COL_BITS_DEF
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // Command and address pins, sampled on mclk
  input  wire cmd_pins_t             cmd,
  // Write strobes, one link clock per lane
  input  wire logic [LANES-1:0]      wstrobe_clk,
  // Data and mask pins
  input  wire logic [8*LANES-1:0]    dq_i,
  output logic      [8*LANES-1:0]    dq_o,
  output logic                       dq_oe,
  input  wire logic [LANES-1:0]      dm_i,
  // Read strobes
  output logic      [LANES-1:0]      dqs_o,
  output logic                       dqs_oe,
  output logic      [LANES-1:0]      dqs_n_o,
  output logic                       dqs_n_oe,
  output logic                       rdqs_o,
  output logic                       rdqs_n_o,
  output logic                       rdqs_oe,
  output logic                       rdqs_n_oe,
  // Status
  output logic [MODE_REGS-1:0][ADDR_W-1:0] mode_regs,
  output logic [NBANK-1:0]           bank_open,
  output logic                       rd_busy,
  output logic                       wr_busy
);

  // ---------------------------------------------------------------------
  // Derived sizes
  // ---------------------------------------------------------------------
  localparam int DW     = 8 * LANES;
  localparam int BEAT_W = $clog2(BURST_LEN);
  localparam int PAIR_W = $clog2(BURST_LEN / 2 + 1);
  localparam int CNT_W  = $clog2(CAS_LAT + 1);
  localparam int MEM_AW = BA_W + ROW_BITS + COL_BITS;
  localparam int DEPTH  = 1 << MEM_AW;

  localparam logic [PAIR_W-1:0] PAIRS     = PAIR_W'(BURST_LEN / 2);
  localparam logic [BEAT_W-1:0] LAST_BEAT = BEAT_W'(BURST_LEN - 1);
  localparam logic [CNT_W-1:0]  WAIT_LOAD = CNT_W'(CAS_LAT - 1);

  typedef struct packed {
    logic [MODE_REGS-1:0][ADDR_W-1:0] mode;
    logic [NBANK-1:0]                 open;
    logic [NBANK-1:0][ROW_BITS-1:0]   row;
    rd_state_t                        rd_st;
    logic [CNT_W-1:0]                 rd_wait;
    logic [BEAT_W-1:0]                rd_beat;
    logic [BA_W-1:0]                  rd_bank;
    logic [COL_BITS-1:0]              rd_col;
    logic                             rd_ap;
    wr_state_t                        wr_st;
    logic [BA_W-1:0]                  wr_bank;
    logic [COL_BITS-1:0]              wr_col;
    logic                             wr_ap;
    logic [LANES-1:0][PAIR_W-1:0]     wr_pairs;
    logic [LANES-1:0]                 s1;
    logic [LANES-1:0]                 s2;
    logic [LANES-1:0]                 s3;
    logic [LANES-1:0]                 seen;
    logic [DW-1:0]                    dq_out;
    logic                             dqs_out;
    logic                             drive;
  } core_t;

  core_t st;
  core_t next_st;

  lane_pair_t [LANES-1:0]            lane_pair;
  logic       [LANES-1:0]            lane_tgl;
  logic       [7:0]                  mem [0:LANES-1][0:DEPTH-1];
  logic [LANES-1:0][1:0]             mem_we;
  logic [LANES-1:0][1:0][MEM_AW-1:0] mem_wa;
  logic [LANES-1:0][1:0][7:0]        mem_wd;
  logic [MEM_AW-1:0]                 mem_ra;
  logic [DW-1:0]                     rd_word;
  logic                              rdqs_en;
  logic                              diff_en;

  function automatic logic [MEM_AW-1:0] mem_addr(
    input logic [BA_W-1:0]     b,
    input logic [ROW_BITS-1:0] r,
    input logic [COL_BITS-1:0] c
  );
    return {b, r, c};
  endfunction : mem_addr

  // ---------------------------------------------------------------------
  // Write capture lanes
  // ---------------------------------------------------------------------
  // one capture per lane
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    ddr2_strobe_lane u_lane (
      .wclk     (wstrobe_clk[g]),
      .resetn   (resetn),
      .dq_in    (dq_i[8*g +: 8]),
      .dm_in    (dm_i[g]),
      .pair     (lane_pair[g]),
      .pair_tgl (lane_tgl[g])
    );
  end

  // ---------------------------------------------------------------------
  // Strobe options
  // ---------------------------------------------------------------------
  // redundant strobe enable
  assign rdqs_en = (LANES == 1) && st.mode[SEL_EMR1][EMR1_RDQS_BIT];
  assign diff_en = !st.mode[SEL_EMR1][EMR1_SE_BIT];

  // ---------------------------------------------------------------------
  // Array read port
  // ---------------------------------------------------------------------
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      rd_word[8*l +: 8] = mem[l][mem_ra];
    end
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic [BEAT_W-1:0] beat;
    logic              all_done;
    logic              masked;
    cmd_code_t         code;
    beat     = '0;
    all_done = 1'b1;
    masked   = 1'b0;
    code     = cmd_code_t'({cmd.ras_n, cmd.cas_n, cmd.we_n});
    next_st  = st;
    mem_we   = '0;
    mem_wa   = '0;
    mem_wd   = '0;

    // Array address of the beat that goes out at the next edge.
    if (st.rd_st == RD_BURST) begin
      beat = BEAT_W'(st.rd_beat + 1'b1);
    end
    mem_ra = mem_addr(st.rd_bank, st.row[st.rd_bank],
                      {st.rd_col[COL_BITS-1:BEAT_W], beat});

    // Read burst engine.
    // strobe edge-aligned to data
    case (st.rd_st)
      RD_IDLE: begin
        next_st.drive   = 1'b0;
        next_st.dqs_out = 1'b0;
      end
      RD_WAIT: begin
        if (st.rd_wait == '0) begin
          next_st.rd_st   = RD_BURST;
          next_st.rd_beat = '0;
          next_st.dq_out  = rd_word;
          next_st.dqs_out = 1'b1;
          next_st.drive   = 1'b1;
        end else begin
          next_st.rd_wait = CNT_W'(st.rd_wait - 1'b1);
        end
      end
      RD_BURST: begin
        if (st.rd_beat == LAST_BEAT) begin
          next_st.rd_st   = RD_IDLE;
          next_st.drive   = 1'b0;
          next_st.dqs_out = 1'b0;
          if (st.rd_ap) begin
            next_st.open[st.rd_bank] = 1'b0;
          end
        end else begin
          next_st.rd_beat = beat;
          next_st.dq_out  = rd_word;
          next_st.dqs_out = ~st.dqs_out;
        end
      end
      default: begin
        next_st.rd_st = RD_IDLE;
        next_st.drive = 1'b0;
      end
    endcase

    // Strobe toggles cross into mclk; a change counts once s2 and s3 agree.
    next_st.s1 = lane_tgl;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int l = 0; l < LANES; l++) begin
      if ((st.s2[l] == st.s3[l]) && (st.s3[l] != st.seen[l])) begin
        next_st.seen[l] = st.s3[l];
        if ((st.wr_st == WR_DATA) && (st.wr_pairs[l] < PAIRS)) begin
          for (int b = 0; b < 2; b++) begin
            masked = lane_pair[l].mask[b] && !rdqs_en;
            mem_we[l][b] = !masked;
            mem_wa[l][b] = mem_addr(st.wr_bank, st.row[st.wr_bank],
                             {st.wr_col[COL_BITS-1:BEAT_W],
                              BEAT_W'({st.wr_pairs[l], b[0]})});
            mem_wd[l][b] = lane_pair[l].data[8*b +: 8];
          end
          next_st.wr_pairs[l] = PAIR_W'(st.wr_pairs[l] + 1'b1);
        end
      end
      if (next_st.wr_pairs[l] != PAIRS) begin
        all_done = 1'b0;
      end
    end

    // Write burst ends when every lane has delivered its pairs.
    if ((st.wr_st == WR_DATA) && all_done) begin
      next_st.wr_st = WR_IDLE;
      if (st.wr_ap) begin
        next_st.open[st.wr_bank] = 1'b0;
      end
    end

    // Command decode.
    // chip select masks commands
    if (!cmd.cs_n && cmd.cke) begin
      case (code)
        CMD_MRS: begin
          next_st.mode[cmd.ba[1:0]] = cmd.addr;
        end
        CMD_ACT: begin
          next_st.open[cmd.ba] = 1'b1;
          next_st.row[cmd.ba]  = cmd.addr[ROW_BITS-1:0];
        end
        CMD_PRE: begin
          if (cmd.addr[PRE_ALL_BIT]) begin
            next_st.open = '0;
          end else begin
            next_st.open[cmd.ba] = 1'b0;
          end
        end
        CMD_WR: begin
          if (st.open[cmd.ba] && (st.rd_st == RD_IDLE) &&
              (st.wr_st == WR_IDLE)) begin
            next_st.wr_st    = WR_DATA;
            next_st.wr_bank  = cmd.ba;
            next_st.wr_col   = cmd.addr[COL_BITS-1:0];
            next_st.wr_ap    = cmd.addr[AP_BIT];
            next_st.wr_pairs = '0;
          end
        end
        CMD_RD: begin
          if (st.open[cmd.ba] && (st.rd_st == RD_IDLE) &&
              (st.wr_st == WR_IDLE)) begin
            next_st.rd_st   = RD_WAIT;
            next_st.rd_wait = WAIT_LOAD;
            next_st.rd_bank = cmd.ba;
            next_st.rd_col  = cmd.addr[COL_BITS-1:0];
            next_st.rd_ap   = cmd.addr[AP_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st       <= '0;
      st.mode  <= {MODE_REGS{MODE_RST}};
      st.open  <= BANK_OPEN_RST;
      st.rd_st <= RD_IDLE;
      st.wr_st <= WR_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------
  // Array write port
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    for (int l = 0; l < LANES; l++) begin
      for (int b = 0; b < 2; b++) begin
        if (mem_we[l][b]) begin
          mem[l][mem_wa[l][b]] <= mem_wd[l][b];
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Pin and status outputs
  // ---------------------------------------------------------------------
  assign dq_o      = st.dq_out;
  assign dq_oe     = st.drive;
  assign dqs_o     = {LANES{st.dqs_out}};
  assign dqs_oe    = st.drive;
  assign dqs_n_o   = {LANES{~st.dqs_out}};
  assign dqs_n_oe  = st.drive && diff_en;
  assign rdqs_o    = st.dqs_out;
  assign rdqs_n_o  = ~st.dqs_out;
  assign rdqs_oe   = st.drive && rdqs_en;
  assign rdqs_n_oe = st.drive && rdqs_en && diff_en;
  assign mode_regs = st.mode;
  assign bank_open = st.open;
  assign rd_busy   = (st.rd_st != RD_IDLE);
  assign wr_busy   = (st.wr_st != WR_IDLE);

endmodule : ddr2_pin_core

/* File: hdl/ddr2_strobe_lane.sv */
// One byte lane of write capture, clocked by the lane's own write strobe.
`timescale 1ns/100ps
module ddr2_strobe_lane
  import ddr2_pin_pkg::*;
(
  // Link side
  input  wire logic       wclk,
  input  wire logic       resetn,
  input  wire logic [7:0] dq_in,
  input  wire logic       dm_in,
  // Core side
  output lane_pair_t      pair,
  output logic            pair_tgl
);

  typedef struct packed {
    logic [7:0] data;
    logic       mask;
  } rise_t;

  typedef struct packed {
    lane_pair_t pair;
    logic       tgl;
  } fall_t;

  rise_t rise;
  rise_t next_rise;
  fall_t fall;
  fall_t next_fall;

  // ---------------------------------------------------------------------
  // Rising edge beat
  // ---------------------------------------------------------------------
  // mask on rising edge
  always_comb begin
    next_rise      = rise;
    next_rise.data = dq_in;
    next_rise.mask = dm_in;
  end

  always_ff @(posedge wclk or negedge resetn) begin
    if (!resetn) begin
      rise <= '0;
    end else begin
      rise <= next_rise;
    end
  end

  // ---------------------------------------------------------------------
  // Falling edge beat completes the pair
  // ---------------------------------------------------------------------
  // The pair stays still for a whole strobe period after the toggle flips,
  // which is what lets the core read it after synchronising the toggle.
  // mask on falling edge
  always_comb begin
    next_fall           = fall;
    next_fall.pair.data = {dq_in, rise.data};
    next_fall.pair.mask = {dm_in, rise.mask};
    next_fall.tgl       = ~fall.tgl;
  end

  always_ff @(negedge wclk or negedge resetn) begin
    if (!resetn) begin
      fall <= '0;
    end else begin
      fall <= next_fall;
    end
  end

  assign pair     = fall.pair;
  assign pair_tgl = fall.tgl;

endmodule : ddr2_strobe_lane

/* File: pkg/ddr2_pin_pkg.sv */
// Shared constants, command codes and carriers for the DDR2 pin core.
package ddr2_pin_pkg;

  // ---------------------------------------------------------------------
  // Pin widths and mode register selection
  // ---------------------------------------------------------------------
  localparam int         BA_W      = 3;
  localparam int         ADDR_W    = 14;
  localparam int         MODE_REGS = 4;
  localparam int         NBANK     = 8;
  localparam logic [1:0] SEL_MR    = 2'h0;
  localparam logic [1:0] SEL_EMR1  = 2'h1;
  localparam logic [1:0] SEL_EMR2  = 2'h2;
  localparam logic [1:0] SEL_EMR3  = 2'h3;

  // ---------------------------------------------------------------------
  // Field positions and values after reset
  // ---------------------------------------------------------------------
  localparam int          AP_BIT          = 10;
  localparam int          PRE_ALL_BIT     = 10;
  localparam int          EMR1_SE_BIT     = 10;
  localparam int          EMR1_RDQS_BIT   = 11;
  localparam logic [13:0] MODE_RST        = 14'h0000;
  localparam logic [7:0]  BANK_OPEN_RST   = 8'h00;

  // ---------------------------------------------------------------------
  // Default counts
  // ---------------------------------------------------------------------
  localparam int CAS_LAT_DEF   = 3;
  localparam int BURST_LEN_DEF = 4;
  localparam int LANES_DEF     = 2;
  localparam int ROW_BITS_DEF  = 2;
  localparam int COL_BITS_DEF  = 4;

  // ---------------------------------------------------------------------
  // Command codes, states and carriers
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000,
    CMD_REF = 3'b001,
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR  = 3'b100,
    CMD_RD  = 3'b101,
    CMD_BST = 3'b110,
    CMD_NOP = 3'b111
  } cmd_code_t;

  typedef enum logic [1:0] {
    RD_IDLE  = 2'b00,
    RD_WAIT  = 2'b01,
    RD_BURST = 2'b10
  } rd_state_t;

  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_DATA = 1'b1
  } wr_state_t;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_t;

  // Bits 7:0 and mask bit 0 hold the rising-edge beat.
  typedef struct packed {
    logic [15:0] data;
    logic [1:0]  mask;
  } lane_pair_t;

endpackage : ddr2_pin_pkg

/* File: testbench/ddr2_ctrl_model.sv */
// Controller-side write link model: strobe, data and mask per lane.
`timescale 1ns/100ps
module ddr2_ctrl_model
  import ddr2_pin_pkg::*;
#(
  parameter int LANES = LANES_DEF
) (
  // Link pins towards the memory
  output logic [LANES-1:0]   wstrobe_clk,
  output logic [8*LANES-1:0] dq_i,
  output logic [LANES-1:0]   dm_i
);
  // Uneven quarters keep the strobe period at 125 ns on a 100 ps grid.
  localparam realtime QA = 31.2;
  localparam realtime QB = 31.3;
  initial begin
    wstrobe_clk = '0;
    dq_i        = '0;
    dm_i        = '0;
  end
  // lane burst, strobe edge centred in each bit
  task automatic send(input int l, input logic [31:0] d,
                      input logic [3:0] m);
    for (int b = 0; b < 4; b++) begin
      dq_i[8*l +: 8] = d[8*b +: 8];
      dm_i[l]        = m[b];
      #QA;
      wstrobe_clk[l] = ~wstrobe_clk[l];
      #QB;
    end
    // Released lines show the inverse of the last beat.
    dq_i[8*l +: 8] = ~d[31:24];
    dm_i[l]        = ~m[3];
  endtask : send
endmodule : ddr2_ctrl_model

/* File: testbench/ddr2_pin_command_data_interface_test.sv */
// Self-checking bench for the pin core with a controller write model.
`timescale 1ns/100ps
module ddr2_pin_command_data_interface_test
  import ddr2_pin_pkg::*;
;
  logic                             mclk = 1'b0;
  logic                             resetn = 1'b0;
  cmd_pins_t                        cmd;
  logic [1:0]                       wstrobe_clk, dm_i, dqs_o, dqs_n_o;
  logic [15:0]                      dq_i, dq_o;
  logic                             dq_oe, dqs_oe, dqs_n_oe, rdqs_o;
  logic                             rdqs_n_o, rdqs_oe, rdqs_n_oe;
  logic                             rd_busy, wr_busy;
  logic [MODE_REGS-1:0][ADDR_W-1:0] mode_regs;
  logic [NBANK-1:0]                 bank_open;
  logic [15:0]                      mem [512];
  logic [15:0]                      exp_q [$];
  logic [1:0]                       row [NBANK];
  int                               n_fail = 0;
  int                               tests_run = 0;
  logic                             se = 1'b0;
  logic [4:0]                       strb;

  always #10 mclk = ~mclk;

  ddr2_pin_core dut (.mclk, .resetn, .cmd, .wstrobe_clk, .dq_i, .dq_o,
    .dq_oe, .dm_i, .dqs_o, .dqs_oe, .dqs_n_o, .dqs_n_oe, .rdqs_o,
    .rdqs_n_o, .rdqs_oe, .rdqs_n_oe, .mode_regs, .bank_open, .rd_busy,
    .wr_busy);
  ddr2_ctrl_model #(.LANES(2)) ctrl (.wstrobe_clk, .dq_i, .dm_i);

  assign strb = {dqs_o, dqs_oe, dqs_n_oe, rdqs_oe};

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (n_fail == 0 && tests_run > 0 && exp_q.size() == 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // command with clock enable high and a valid bank
  task automatic issue(input cmd_code_t c, input logic [2:0] ba,
                       input logic [13:0] a, input logic cs = 1'b0);
    cmd <= {cs, c, 1'b1, ba, a};
    @(negedge mclk);
    cmd <= {1'b0, CMD_NOP, 1'b1, 3'h0, 14'h0};
    @(negedge mclk);
  endtask : issue

  task automatic settle;
    int i;
    for (i = 0; i < 30 && (rd_busy !== 1'b0 || wr_busy !== 1'b0); i++)
      @(negedge mclk);
    check(rd_busy | wr_busy, 0);
  endtask : settle

  task automatic wr_burst(input logic [2:0] b, input logic [3:0] c,
                          input logic [63:0] d, input logic [7:0] m);
    for (int k = 0; k < 4; k++)
      for (int l = 0; l < 2; l++)
        if (!m[2*k+l])
          mem[{b, row[b], c[3:2], k[1:0]}][8*l +: 8] = d[16*k+8*l +: 8];
    issue(CMD_WR, b, {10'h0, c});
    fork
      ctrl.send(0, {d[55:48], d[39:32], d[23:16], d[7:0]},
                {m[6], m[4], m[2], m[0]});
      #40 ctrl.send(1, {d[63:56], d[47:40], d[31:24], d[15:8]},
                    {m[7], m[5], m[3], m[1]});
    join
    settle();
  endtask : wr_burst

  task automatic rd_burst(input logic [2:0] b, input logic [3:0] c,
                          input logic ap);
    for (int k = 0; k < 4; k++)
      exp_q.push_back(mem[{b, row[b], c[3:2], k[1:0]}]);
    issue(CMD_RD, b, {3'h0, ap, 6'h0, c});
    settle();
  endtask : rd_burst

  // Strobe is high on even beats; complement only while differential.
  always @(negedge mclk)
    if (dq_oe === 1'b1) begin
      check(strb, {{2{exp_q.size() % 2 == 0}}, 1'b1, !se, 1'b0});
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("unexpected at %0t: read beat with none due", $time);
      end else
        check(dq_o, exp_q.pop_front());
    end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    logic [13:0] v;
    logic [2:0]  b;
    logic [3:0]  c;
    void'($urandom(52911));
    cmd = {1'b1, CMD_NOP, 1'b1, 3'h0, 14'h0};
    repeat (4) @(negedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    check(bank_open, BANK_OPEN_RST);
    check(mode_regs[1], MODE_RST);
    for (int i = 3; i >= 0; i--) begin
      v = 14'($urandom);
      b = 3'($urandom);
      b[1:0] = i[1:0];
      if (i == 1)
        v[11:10] = 2'b10;
      issue(CMD_MRS, b, v);
      check(mode_regs[i], v);
    end
    issue(CMD_MRS, 3'h0, ~v, 1'b1);
    check(mode_regs[0], v);
    for (int n = 0; n < 3; n++) begin
      b = 3'(2 * n + ($urandom & 1));
      row[b] = 2'($urandom);
      c = 4'($urandom);
      if (n == 2) begin
        issue(CMD_MRS, 3'h1, 14'h0400);
        se = 1'b1;
      end
      issue(CMD_ACT, b, {12'h0, row[b]});
      check(bank_open[b], 1'b1);
      wr_burst(b, c, {$urandom, $urandom}, 8'h00);
      wr_burst(b, c, {$urandom, $urandom}, 8'($urandom));
      rd_burst(b, c, n == 2);
    end
    check(bank_open[b], 1'b0);
    issue(CMD_RD, b, 14'h0);
    check(rd_busy, 1'b0);
    issue(CMD_ACT, 3'h6, 14'h0);
    issue(CMD_ACT, 3'h7, 14'h0);
    issue(CMD_PRE, 3'h6, 14'h0);
    check(bank_open[7:6], 2'b10);
    issue(CMD_PRE, 3'h6, 14'h0400);
    check(bank_open, 8'h00);
    resetn <= 1'b0;
    @(negedge mclk);
    check(mode_regs[0], MODE_RST);
    resetn <= 1'b1;
    @(negedge mclk);
    print_verdict();
  end

  initial begin
    #50000;
    n_fail++;
    print_verdict();
  end
endmodule : ddr2_pin_command_data_interface_test

/* File: testbench/ddr2_pin_core_sva.sv */
// Checker for command, read and strobe pin behaviour of the pin core.
`timescale 1ns/100ps
module ddr2_pin_core_chk
  import ddr2_pin_pkg::*;
#(
  parameter int LANES   = LANES_DEF,
  parameter int CAS_LAT = CAS_LAT_DEF
) (
  // Clock and reset
  input wire logic                         mclk,
  input wire logic                         resetn,
  // Observed pins
  input wire cmd_pins_t                    cmd,
  input wire logic                         dq_oe,
  input wire logic [LANES-1:0]             dqs_o,
  input wire logic                         dqs_oe,
  input wire logic [LANES-1:0]             dqs_n_o,
  input wire logic                         dqs_n_oe,
  input wire logic                         rdqs_o,
  input wire logic                         rdqs_n_o,
  input wire logic                         rdqs_oe,
  input wire logic                         rdqs_n_oe,
  input wire logic [MODE_REGS-1:0][ADDR_W-1:0] mode_regs,
  input wire logic [NBANK-1:0]             bank_open,
  input wire logic                         rd_busy,
  input wire logic                         wr_busy
);
  localparam int RD_DLY = CAS_LAT + 1;
  logic      take;
  logic      rd_go;
  cmd_code_t code;
  assign take  = !cmd.cs_n && cmd.cke;
  assign code  = cmd_code_t'({cmd.ras_n, cmd.cas_n, cmd.we_n});
  assign rd_go = take && code == CMD_RD && bank_open[cmd.ba] &&
                 !rd_busy && !wr_busy;

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_mrs_store: assert property (
    take && code == CMD_MRS |=>
    mode_regs[$past(cmd.ba[1:0])] == $past(cmd.addr))
    else $error("mode register not loaded");
  a_cs_mask: assert property (
    cmd.cs_n |=> $stable(mode_regs))
    else $error("deselected command changed a mode register");
  a_act_open: assert property (
    take && code == CMD_ACT |=> bank_open[$past(cmd.ba)])
    else $error("activated bank not open");
  a_pre_all: assert property (
    take && code == CMD_PRE && cmd.addr[PRE_ALL_BIT] |=> bank_open == '0)
    else $error("precharge all left a bank open");
  a_pre_one: assert property (
    take && code == CMD_PRE && !cmd.addr[PRE_ALL_BIT] |=>
    !bank_open[$past(cmd.ba)])
    else $error("precharged bank still open");
  a_read_burst: assert property (
    rd_go |-> ##RD_DLY dq_oe [*4] ##1 !dq_oe)
    else $error("read burst timing wrong");
  a_dqs_edge: assert property (
    dq_oe && $past(dq_oe) |->
    dqs_o[0] != $past(dqs_o[0]) && dqs_o == {LANES{dqs_o[0]}})
    else $error("read strobe did not toggle per beat");
  a_strobe_en: assert property (
    dqs_oe == dq_oe && dqs_n_o == ~dqs_o &&
    dqs_n_oe == (dq_oe && !mode_regs[1][EMR1_SE_BIT]))
    else $error("strobe enables wrong");
  a_rdqs_en: assert property (
    rdqs_oe == (dq_oe && LANES == 1 && mode_regs[1][EMR1_RDQS_BIT]))
    else $error("redundant strobe enable wrong");
  a_rdqs_pins: assert property (
    rdqs_o == dqs_o[0] && rdqs_n_o == !dqs_o[0] &&
    rdqs_n_oe == (rdqs_oe && !mode_regs[1][EMR1_SE_BIT]))
    else $error("redundant strobe pins wrong");
  a_one_driver: assert property (
    wr_busy |-> !dq_oe)
    else $error("data driven during write");

  c_read: cover property (rd_go);
  c_write: cover property ($fell(wr_busy));
  c_emr1: cover property (take && code == CMD_MRS && cmd.ba[1:0] == SEL_EMR1);
  c_single: cover property (dqs_oe && !dqs_n_oe);
endmodule : ddr2_pin_core_chk

bind ddr2_pin_core ddr2_pin_core_chk #(.LANES(LANES), .CAS_LAT(CAS_LAT))
  u_chk (.mclk, .resetn, .cmd, .dq_oe, .dqs_o, .dqs_oe, .dqs_n_o,
         .dqs_n_oe, .rdqs_o, .rdqs_n_o, .rdqs_oe, .rdqs_n_oe, .mode_regs,
         .bank_open, .rd_busy, .wr_busy);
